// ### shared/power_mode_map.svh
/*
 * Offsets, field positions, reset values and timing counts of the
 * power-mode and bus-strobe control block.
 * Assumes an 8-bit register port and one clock at the oscillator rate.
 */
`ifndef POWER_MODE_MAP_SVH
`define POWER_MODE_MAP_SVH

// register offsets
`define PWR_CTRL_ADDR 8'h87
`define IRQ_CFG_ADDR 8'h88
`define AUX_CONTROL_ADDR 8'h8E
`define STATUS_ADDR 8'h8F

// pwr_ctrl fields
`define PWR_IDLE_BIT 0
`define PWR_DOWN_BIT 1
`define PWR_PCA_IDLE_RUN_BIT 2

// irq_cfg fields
`define IRQ_EN0_BIT 0
`define IRQ_EN1_BIT 1
`define IRQ_LVL0_BIT 2
`define IRQ_LVL1_BIT 3

// aux_control fields and reset values
`define AUX_EMISSION_BIT 0
`define AUX_RESET 8'h00
`define IRQ_CFG_RESET 4'h0

// machine cycle: six states of two oscillator periods each
`define SLOT_LAST 3'h5
`define ALE_SLOT_A 3'h0
`define ALE_SLOT_B 3'h3
`define MC_OSC_PERIODS 12
`define RST_HOLD_MC 2

`endif

// ### shared/power_mode_pkg.sv
/*
 * Types of the power-mode and bus-strobe control block.
 * Assumes power_mode_map.svh is on the include path.
 */
package power_mode_pkg;
`include "power_mode_map.svh"

   // operating modes, gray coded along run-idle-reset and run-down-wake
   typedef enum logic [2:0] {
      RUN_M = 3'h0,
      IDLE_M = 3'h1,
      IDLE_RST_M = 3'h3,
      PD_M = 3'h2,
      PD_WAKE_M = 3'h6,
      ONCE_M = 3'h7
   } mode_t;

   // complete state of the block
   typedef struct packed {
      mode_t mode;
      logic phase;
      logic [2:0] slot;
      logic xmc;
      logic [4:0] rst_cnt;
      logic core_rst;
      logic ea_lat;
      logic emission_reduction;
      logic pca_idle_run;
      logic [3:0] irq_cfg;
      logic [7:0] rdata;
      logic wake;
      logic [1:0] ea_s;
      logic [1:0] rp_s;
      logic [1:0] i0_s;
      logic [1:0] i1_s;
      logic [1:0] ale_s;
      logic [1:0] program_store_strobe_s;
   } st_t;

endpackage

// ### verilog/power_mode_bus_strobe_ctrl.sv
/*
 * Power-mode, reset and external bus strobe control of an 8-bit
 * microcontroller: address-latch and program-store strobes, external
 * access select, idle, power-down, emulation test mode, emission reduction.
 * Assumes clk is the oscillator input, rst a power-on reset, and a core
 * that reports external data cycles and enabled interrupts on plain ports.
 */
// Design decision made here: the address-and-strobe port.
//
// Behaviour
// [RULE_01] address-latch strobe at one sixth oscillator rate
// [RULE_02] one address-latch pulse dropped per data access
// [RULE_03] program strobe twice per cycle, two skipped
// [RULE_04] select low fetches all code externally
// [RULE_05] lock bits latch select level at reset
// [RULE_06] divide-by-two stage clocks internal timing
// [RULE_07] idle stops execution, keeps registers and RAM
// [RULE_08] idle ends on reset or enabled interrupt
// [RULE_09] counter array runs or pauses in idle
// [RULE_10] power-down stops oscillator, retains contents
// [RULE_11] power-down exit by reset or external interrupt
// [RULE_12] party holds wake signal until oscillator settles
// [RULE_13] level interrupt low restarts, high completes exit
// [RULE_14] resume after instruction that requested power-down
// [RULE_15] reset from idle blocks RAM two cycles
// [RULE_16] avoid port writes right after idle request
// [RULE_17] strobe held low through reset enters emulation
// [RULE_18] emulation floats port0, weak pulls strobes
// [RULE_19] aux bit zero suppresses address-latch on fetches
// [RULE_20] suppression holds until cleared or reset
// [RULE_21] strobe and port states in idle, power-down
// [RULE_22] reset pin two machine cycles resets device
// [RULE_23] machine cycle is twelve oscillator periods
`timescale 1ns/1ps
`include "power_mode_map.svh"

module power_mode_bus_strobe_ctrl
   import power_mode_pkg::*;
#(
   parameter int RST_HOLD_MC = `RST_HOLD_MC
) (
   input wire logic clk, // oscillator input
   input wire logic rst, // power-on reset, async, active high
   input wire logic [7:0] reg_addr, // register address
   input wire logic [7:0] reg_wdata, // register write data
   input wire logic reg_wr, // register write strobe
   input wire logic reg_rd, // register read strobe
   output logic [7:0] reg_rdata, // read data, cycle after strobe
   input wire logic reset_pin, // reset pin level
   input wire logic external_access_select, // select pin level
   input wire logic [1:0] lock_bits, // program lock bits, same clock
   input wire logic ext_irq_zero_n, // external interrupt zero pin
   input wire logic ext_irq_one_n, // external interrupt one pin
   input wire logic irq_pending, // enabled interrupt raised by core
   input wire logic xdata_req, // core: next machine cycle is a data access
   input wire logic ale_i, // address-latch pin level
   output logic ale_o, // address-latch drive value
   output logic ale_oe, // address-latch driven
   output logic ale_weak_pu, // address-latch weak pullup on
   input wire logic program_store_strobe_n_i, // program strobe pin level
   output logic program_store_strobe_n_o, // program strobe drive value, low active
   output logic program_store_strobe_n_oe, // program strobe driven
   output logic program_store_strobe_weak_pu, // program strobe weak pullup on
   output logic osc_run, // oscillator enabled
   output logic state_tick, // one-cycle enable per machine state
   output logic mc_start, // one-cycle pulse at machine cycle start
   output logic cpu_run, // core may execute
   output logic ram_inhibit, // block internal RAM access
   output logic sfr_reset, // reset of special function registers
   output logic wake_pulse, // power-down left by interrupt
   output logic pca_run, // counter array clock enable
   output logic code_external, // fetch code from external memory
   output logic port0_float, // port 0 floats
   output logic port2_addr, // port 2 carries address, else data
   output logic once_mode // emulation test mode active
);

   localparam int RST_CLKS = `MC_OSC_PERIODS * RST_HOLD_MC;
   localparam logic [4:0] RST_LAST = 5'(RST_CLKS - 1);

   // elaboration check: hold count must fit its counter
   generate
      if (RST_HOLD_MC < 1 || RST_CLKS > 31) begin : g_bad_hold
         $error("RST_HOLD_MC out of range");
      end
   endgenerate

   st_t s_r;
   st_t s_nxt;
   logic osc_on;
   logic tick;
   logic ea_eff;
   logic irq_low;
   logic run_ok;
   logic ale_pulse;
   logic program_store_strobe_act;

   // register address match, shared by write and read decode
   function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
      hit = (a == r);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // derived levels

   // oscillator stops only in power-down proper
   assign osc_on = (s_r.mode != PD_M); // see [RULE_10]
   // divide-by-two: one machine state every second oscillator period
   assign tick = osc_on & s_r.phase; // see [RULE_06]
   // lock bits freeze the select level taken at reset
   assign ea_eff = (|lock_bits) ? s_r.ea_lat : s_r.ea_s[1]; // see [RULE_05]
   // level-triggered external interrupt held low and enabled
   assign irq_low = (s_r.irq_cfg[`IRQ_EN0_BIT] & s_r.irq_cfg[`IRQ_LVL0_BIT] & ~s_r.i0_s[1])
      | (s_r.irq_cfg[`IRQ_EN1_BIT] & s_r.irq_cfg[`IRQ_LVL1_BIT] & ~s_r.i1_s[1]); // see [RULE_13]
   assign run_ok = (s_r.mode == RUN_M) & ~s_r.core_rst;
   // two address-latch states per machine cycle, second dropped on data access
   assign ale_pulse = (s_r.slot == `ALE_SLOT_A)
      | ((s_r.slot == `ALE_SLOT_B) & ~s_r.xmc); // see [RULE_01] [RULE_02]
   // program strobe low in two pairs of states, none on data access
   assign program_store_strobe_act = (s_r.slot != `ALE_SLOT_A) & (s_r.slot != `ALE_SLOT_B)
      & ~s_r.xmc; // see [RULE_03]

   ////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      s_nxt = s_r;
      // two-flop synchronisers on every pin
      s_nxt.ea_s = {s_r.ea_s[0], external_access_select};
      s_nxt.rp_s = {s_r.rp_s[0], reset_pin};
      s_nxt.i0_s = {s_r.i0_s[0], ext_irq_zero_n};
      s_nxt.i1_s = {s_r.i1_s[0], ext_irq_one_n};
      s_nxt.ale_s = {s_r.ale_s[0], ale_i};
      s_nxt.program_store_strobe_s = {s_r.program_store_strobe_s[0], program_store_strobe_n_i};
      s_nxt.wake = 1'b0;
      s_nxt.rdata = 8'h00;

      // machine state sequencer, twelve oscillator periods a cycle
      if (osc_on) begin
         s_nxt.phase = ~s_r.phase; // see [RULE_06]
      end
      if (tick) begin
         if (s_r.slot == `SLOT_LAST) begin
            s_nxt.slot = 3'h0; // see [RULE_23]
            s_nxt.xmc = xdata_req & run_ok;
         end else begin
            s_nxt.slot = s_r.slot + 3'h1;
         end
      end

      // reset pin must stand two machine cycles with oscillator running
      if (s_r.rp_s[1] & osc_on) begin
         if (s_r.rst_cnt != RST_LAST) begin
            s_nxt.rst_cnt = s_r.rst_cnt + 5'h01;
         end else begin
            s_nxt.core_rst = 1'b1; // see [RULE_22]
         end
      end else begin
         s_nxt.rst_cnt = 5'h00;
         if (~s_r.rp_s[1]) begin
            s_nxt.core_rst = 1'b0;
         end
      end

      // register writes, only while the core runs
      if (reg_wr & run_ok) begin
         if (hit(reg_addr, `AUX_CONTROL_ADDR)) begin
            // suppression stays until written back to zero or internal reset
            s_nxt.emission_reduction = reg_wdata[`AUX_EMISSION_BIT]; // see [RULE_19] [RULE_20]
         end else if (hit(reg_addr, `IRQ_CFG_ADDR)) begin
            s_nxt.irq_cfg = reg_wdata[3:0];
         end else if (hit(reg_addr, `PWR_CTRL_ADDR)) begin
            s_nxt.pca_idle_run = reg_wdata[`PWR_PCA_IDLE_RUN_BIT]; // see [RULE_09]
         end
      end

      // register reads, data in the following cycle only
      if (reg_rd) begin
         if (hit(reg_addr, `AUX_CONTROL_ADDR)) begin
            s_nxt.rdata = {7'h00, s_r.emission_reduction};
         end else if (hit(reg_addr, `IRQ_CFG_ADDR)) begin
            s_nxt.rdata = {4'h0, s_r.irq_cfg};
         end else if (hit(reg_addr, `PWR_CTRL_ADDR)) begin
            s_nxt.rdata = {5'h00, s_r.pca_idle_run, 2'h0};
         end else if (hit(reg_addr, `STATUS_ADDR)) begin
            s_nxt.rdata = {2'h0, s_r.core_rst, (s_r.mode == ONCE_M), ea_eff, s_r.mode};
         end else begin
            s_nxt.rdata = 8'h00;
         end
      end

      // mode sequencer
      case (s_r.mode)
         RUN_M: begin
            // power-down request wins over idle in the same write
            if (reg_wr & run_ok & hit(reg_addr, `PWR_CTRL_ADDR)) begin
               if (reg_wdata[`PWR_DOWN_BIT]) begin
                  s_nxt.mode = PD_M; // see [RULE_10]
               end else if (reg_wdata[`PWR_IDLE_BIT]) begin
                  s_nxt.mode = IDLE_M; // see [RULE_07]
               end
            end
         end
         IDLE_M: begin
            if (s_r.rp_s[1]) begin
               s_nxt.mode = IDLE_RST_M; // see [RULE_15]
            end else if (irq_pending | irq_low) begin
               s_nxt.mode = RUN_M; // see [RULE_08]
            end
         end
         IDLE_RST_M: begin
            // core runs on with RAM blocked until the reset takes over
            if (s_nxt.core_rst | ~s_r.rp_s[1]) begin
               s_nxt.mode = RUN_M; // see [RULE_15]
            end
         end
         PD_M: begin
            // reset pin or level interrupt restarts the oscillator
            if (s_r.rp_s[1] | irq_low) begin
               s_nxt.mode = PD_WAKE_M; // see [RULE_11] [RULE_13]
            end
         end
         PD_WAKE_M: begin
            if (s_r.core_rst) begin
               s_nxt.mode = RUN_M; // see [RULE_11]
            end else if (~s_r.rp_s[1] & ~irq_low) begin
               // release of the interrupt pin completes the exit
               s_nxt.mode = RUN_M; // see [RULE_13]
               s_nxt.wake = 1'b1; // see [RULE_14]
            end
         end
         ONCE_M: begin
            if (s_nxt.core_rst) begin
               s_nxt.mode = RUN_M; // see [RULE_18]
            end
         end
         default: begin
            s_nxt.mode = RUN_M;
         end
      endcase

      // internal reset clears registers but leaves RAM alone
      if (s_r.core_rst) begin
         s_nxt.emission_reduction = 1'b0; // see [RULE_19] [RULE_11]
         s_nxt.pca_idle_run = 1'b0;
         s_nxt.irq_cfg = `IRQ_CFG_RESET;
         s_nxt.mode = RUN_M;
         s_nxt.xmc = 1'b0;
         if (~s_nxt.core_rst) begin
            // release: take the select strap, check for emulation entry
            s_nxt.ea_lat = s_r.ea_s[1]; // see [RULE_05]
            if (~s_r.ale_s[1] & s_r.program_store_strobe_s[1]) begin
               s_nxt.mode = ONCE_M; // see [RULE_17]
            end
         end
      end
   end

   // state register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_r <= '{mode: RUN_M, phase: 1'b0, slot: 3'h0, xmc: 1'b0, rst_cnt: 5'h00,
            core_rst: 1'b1, ea_lat: 1'b1, emission_reduction: 1'b0, pca_idle_run: 1'b0,
            irq_cfg: `IRQ_CFG_RESET, rdata: `AUX_RESET, wake: 1'b0, ea_s: 2'h0,
            rp_s: 2'h3, i0_s: 2'h3, i1_s: 2'h3, ale_s: 2'h3, program_store_strobe_s: 2'h3};
      end else begin
         s_r <= s_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs

   // core and system controls
   assign reg_rdata = s_r.rdata;
   assign osc_run = osc_on;
   assign state_tick = tick;
   assign mc_start = tick & (s_r.slot == `SLOT_LAST);
   assign cpu_run = run_ok | (s_r.mode == IDLE_RST_M); // see [RULE_07] [RULE_15]
   assign ram_inhibit = (s_r.mode == IDLE_RST_M); // see [RULE_15]
   assign sfr_reset = s_r.core_rst; // see [RULE_22]
   assign wake_pulse = s_r.wake; // see [RULE_14]
   assign pca_run = osc_on & (((s_r.mode != IDLE_M) & (s_r.mode != IDLE_RST_M))
      | s_r.pca_idle_run); // see [RULE_09]
   assign code_external = ~ea_eff; // see [RULE_04]
   assign once_mode = (s_r.mode == ONCE_M);
   assign port0_float = once_mode | (code_external & (s_r.mode != RUN_M)); // see [RULE_21] [RULE_18]
   assign port2_addr = code_external & ((s_r.mode == IDLE_M) | (s_r.mode == IDLE_RST_M)); // see [RULE_21]

   // strobe pin drive per mode
   always_comb begin
      ale_o = 1'b1;
      ale_oe = 1'b1;
      ale_weak_pu = 1'b0;
      program_store_strobe_n_o = 1'b1;
      program_store_strobe_n_oe = 1'b1;
      program_store_strobe_weak_pu = 1'b0;
      if (s_r.core_rst | once_mode) begin
         // released to weak pullups so the emulator can pull them
         ale_oe = 1'b0; // see [RULE_18]
         ale_weak_pu = 1'b1;
         program_store_strobe_n_oe = 1'b0;
         program_store_strobe_weak_pu = 1'b1;
      end else if ((s_r.mode == PD_M) | (s_r.mode == PD_WAKE_M)) begin
         ale_o = 1'b0; // see [RULE_21]
         program_store_strobe_n_o = 1'b0;
      end else if (s_r.mode == RUN_M) begin
         if (s_r.emission_reduction & ~s_r.xmc) begin
            // code fetch cycle with suppression: weak high only
            ale_oe = 1'b0; // see [RULE_19]
            ale_weak_pu = 1'b1;
         end else begin
            ale_o = ale_pulse; // see [RULE_01] [RULE_02]
         end
         program_store_strobe_n_o = ~(program_store_strobe_act & code_external); // see [RULE_03]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // assertions

   // second pulse of a cycle is followed by a pulse six periods later
   a_ale_rate: assert property (@(posedge clk)
      disable iff (rst || s_r.core_rst || s_r.mode != RUN_M || s_r.emission_reduction)
      $rose(ale_o) && s_r.slot == `ALE_SLOT_B
      |-> ale_o [*2] ##1 !ale_o [*4] ##1 ale_o) // see [RULE_01]
      else $error("address-latch strobe not at one sixth rate");

   // data access drops the second pulse
   a_ale_skip: assert property (@(posedge clk)
      disable iff (rst || s_r.core_rst || s_r.mode != RUN_M || s_r.emission_reduction)
      $rose(s_r.xmc) && s_r.slot == 3'h0 |-> ##6 !ale_o ##1 !ale_o) // see [RULE_02]
      else $error("address-latch pulse not skipped on data access");

   // program strobe quiet through a data access cycle
   a_program_store_strobe_skip: assert property (@(posedge clk) disable iff (rst)
      run_ok && s_r.xmc |-> program_store_strobe_n_o && program_store_strobe_n_oe) // see [RULE_03]
      else $error("program strobe active during data access");

   // external fetch: strobe goes low two periods after cycle start
   a_program_store_strobe_twice: assert property (@(posedge clk)
      disable iff (rst || s_r.core_rst || s_r.mode != RUN_M)
      $rose(ale_o) && s_r.slot == `ALE_SLOT_A && code_external && !s_r.xmc
      |-> ##2 !program_store_strobe_n_o ##4 program_store_strobe_n_o ##2 !program_store_strobe_n_o) // see [RULE_03]
      else $error("program strobe not twice per cycle");

   // locked part uses the select level taken at reset
   a_ea_latch: assert property (@(posedge clk) disable iff (rst)
      (|lock_bits) && $past(|lock_bits) && !s_r.core_rst && !$past(s_r.core_rst)
      |-> $stable(code_external)) // see [RULE_05] [RULE_04]
      else $error("select level not latched");

   // state sequencer advances once per two periods
   a_div_two: assert property (@(posedge clk) disable iff (rst)
      osc_on && !s_r.phase && $past(osc_on) |=> s_r.slot == $past(s_r.slot)) // see [RULE_06]
      else $error("machine state advanced on odd period");

   // idle holds strobes high; power-down stops and drives low
   a_idle_strobes: assert property (@(posedge clk) disable iff (rst)
      s_r.mode == IDLE_M && !s_r.core_rst |-> ale_o && ale_oe && program_store_strobe_n_o && !cpu_run) // see [RULE_21] [RULE_07]
      else $error("idle strobe state wrong");
   a_pd_state: assert property (@(posedge clk) disable iff (rst)
      s_r.mode == PD_M |-> !osc_run && !ale_o && !program_store_strobe_n_o && !cpu_run && !pca_run) // see [RULE_10] [RULE_21]
      else $error("power-down state wrong");

   // reset takes effect after the full hold time
   a_rst_hold: assert property (@(posedge clk) disable iff (rst)
      $rose(s_r.core_rst) |-> $past(s_r.rst_cnt) == RST_LAST) // see [RULE_22]
      else $error("internal reset before hold time");

   // suppression keeps the strobe undriven during fetch cycles
   a_rfi_ale: assert property (@(posedge clk) disable iff (rst)
      run_ok && s_r.emission_reduction && !s_r.xmc |-> !ale_oe && ale_weak_pu) // see [RULE_19] [RULE_20]
      else $error("address-latch strobe not suppressed");

   // reset out of idle blocks RAM while the core runs on
   a_idle_ram: assert property (@(posedge clk) disable iff (rst)
      s_r.mode == IDLE_M && s_r.rp_s[1] |=> ram_inhibit && cpu_run) // see [RULE_15] [RULE_08]
      else $error("RAM not blocked on reset from idle");

   // pin release after wake completes exit with one wake pulse
   a_pd_wake: assert property (@(posedge clk) disable iff (rst)
      s_r.mode == PD_WAKE_M && !s_r.core_rst && !s_r.rp_s[1] && !irq_low
      |=> s_r.mode == RUN_M && wake_pulse ##1 !wake_pulse) // see [RULE_13] [RULE_14]
      else $error("power-down exit by interrupt wrong");

endmodule // power_mode_bus_strobe_ctrl

// ### testbench/strobe_pin_partner.sv
/*
 * Far-side pin model: strobe wires, emulator hold and a level wake source.
 * Assumes it shares the block's clock and that strobe ports are split by enable.
 */
`timescale 1ns/1ps

module strobe_pin_partner #(
   parameter int SETTLE = 20 // oscillator settling in cycles, plain default
) (
   input wire logic clk, // oscillator clock
   input wire logic latch_o, // latch strobe drive value
   input wire logic latch_oe, // latch strobe driven
   input wire logic latch_pu, // latch strobe weak pullup
   input wire logic prog_n_o, // program strobe drive value
   input wire logic prog_n_oe, // program strobe driven
   input wire logic prog_pu, // program strobe weak pullup
   input wire logic osc_on, // oscillator running
   input wire logic hold_low, // emulator pulls latch strobe low
   input wire logic wake_req, // start a power-down wake
   output logic latch_pin, // latch strobe wire
   output logic prog_n_pin, // program strobe wire
   output logic irq_n = 1'b1 // level interrupt zero wire
);
logic latch_q = 1'b0;
logic prog_q = 1'b0;
int settle_cnt = 0;
////////////////////////////////////////////////////////////////////////////////
// wire level: driver, then emulator on the latch wire only, then weak pullup, else a changing value
always_comb begin
   latch_pin = latch_oe ? latch_o : hold_low ? 1'b0 : latch_pu ? 1'b1 : ~latch_q;
   prog_n_pin = prog_n_oe ? prog_n_o : prog_pu ? 1'b1 : ~prog_q;
end
// wake pin held low until the oscillator has run SETTLE cycles
always @(posedge clk) begin
   latch_q <= latch_pin;
   prog_q <= prog_n_pin;
   if (wake_req) begin
      irq_n <= 1'b0;
      settle_cnt <= 0;
   end else if (!irq_n && osc_on) begin
      settle_cnt <= settle_cnt + 1;
      if (settle_cnt >= SETTLE) irq_n <= 1'b1;
   end
end
endmodule // strobe_pin_partner

// ### testbench/test_power_mode_bus_strobe_ctrl.sv
/*
 * Self-checking bench: register port tasks, strobe counting, mode tests.
 * Assumes the block and the pin partner; one 100 MHz clock.
 */
`timescale 1ns/1ps

module test_power_mode_bus_strobe_ctrl;
logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rpin = 1'b0, sel = 1'b0;
logic pend = 1'b0, xd = 1'b0, hold = 1'b0, wreq = 1'b0;
logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, v;
logic [1:0] lock = 2'b00;
logic ale_i, ale_o, ale_oe, ale_pu, pg_i, pg_o, pg_oe, pg_pu, osc, irq0_n;
logic tick, mcs, cpu, rinh, sreset, wake, programmable_counter_array, cext, p0f, p2a, once;
int err_total = 0, cmp_count = 0, cyc = 0, n, ale_cnt = 0, prg_cnt = 0, a0, p0;
int mc_cnt = 0, tk_cnt = 0, m0, t0;
logic ale_q = 1'b0, pg_q = 1'b1;

power_mode_bus_strobe_ctrl u_power_mode_bus_strobe_ctrl (.clk(clk), .rst(rst),
   .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
   .reset_pin(rpin), .external_access_select(sel), .lock_bits(lock),
   .ext_irq_zero_n(irq0_n), .ext_irq_one_n(1'b1), .irq_pending(pend), .xdata_req(xd),
   .ale_i(ale_i), .ale_o(ale_o), .ale_oe(ale_oe), .ale_weak_pu(ale_pu),
   .program_store_strobe_n_i(pg_i), .program_store_strobe_n_o(pg_o), .program_store_strobe_n_oe(pg_oe), .program_store_strobe_weak_pu(pg_pu),
   .osc_run(osc), .state_tick(tick), .mc_start(mcs), .cpu_run(cpu), .ram_inhibit(rinh),
   .sfr_reset(sreset), .wake_pulse(wake), .pca_run(programmable_counter_array), .code_external(cext),
   .port0_float(p0f), .port2_addr(p2a), .once_mode(once));
strobe_pin_partner u_strobe_pin_partner (.clk(clk), .latch_o(ale_o), .latch_oe(ale_oe),
   .latch_pu(ale_pu), .prog_n_o(pg_o), .prog_n_oe(pg_oe), .prog_pu(pg_pu), .osc_on(osc),
   .hold_low(hold), .wake_req(wreq), .latch_pin(ale_i), .prog_n_pin(pg_i), .irq_n(irq0_n));
////////////////////////////////////////////////////////////////////////////////
// clock, cycle ceiling and strobe edge counters
initial begin
   forever #5 clk = ~clk;
end
always @(posedge clk) begin
   cyc++;
   if (ale_oe && ale_o && !ale_q) ale_cnt++;
   if (pg_oe && !pg_o && pg_q) prg_cnt++;
   if (mcs) mc_cnt++;
   if (tick) tk_cnt++;
   ale_q = ale_o;
   pg_q = pg_o;
   if (cyc == 20000) begin
      err_total++;
      end_of_test();
   end
end
////////////////////////////////////////////////////////////////////////////////
// compare, report and register port tasks
task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
   cmp_count++;
   if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
   end
endtask
task automatic end_of_test();
   $display("compares %0d mismatches %0d", cmp_count, err_total);
   if (err_total == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
   else $display("TESTS FAILED");
   $finish;
endtask
task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
   @(posedge clk);
   addr <= a;
   wdata <= d;
   wr <= 1'b1;
   @(posedge clk);
   wr <= 1'b0;
endtask
task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
   @(posedge clk);
   addr <= a;
   rd <= 1'b1;
   @(posedge clk);
   rd <= 1'b0;
   #1 d = rdata;
endtask
// strobe edges over a whole number of machine cycles
task automatic strobes(input int len, input int e_ale, input int e_prg);
   @(posedge clk);
   #1 a0 = ale_cnt;
   p0 = prg_cnt;
   m0 = mc_cnt;
   t0 = tk_cnt;
   repeat (len) @(posedge clk);
   #1 chk("latch strobes", 8'(e_ale), 8'(ale_cnt - a0));
   chk("program strobes", 8'(e_prg), 8'(prg_cnt - p0));
   chk("machine cycles", 8'(len / 12), 8'(mc_cnt - m0));
   chk("state ticks", 8'(len / 2), 8'(tk_cnt - t0));
endtask
task automatic pin_reset();
   @(posedge clk);
   rpin <= 1'b1;
   repeat (40) @(posedge clk);
   #1 chk("sfr reset", 8'h01, {7'h00, sreset});
   rpin <= 1'b0;
   for (n = 0; n < 50 && sreset !== 1'b0; n++) @(posedge clk);
endtask
////////////////////////////////////////////////////////////////////////////////
// main sequence
initial begin
   repeat (6) @(posedge clk);
   rst <= 1'b0;
   for (n = 0; n < 50 && sreset !== 1'b0; n++) @(posedge clk);
   rd_reg(8'h8E, v); chk("aux reset", 8'h00, v);
   rd_reg(8'h8F, v); chk("status run", 8'h00, v);
   $display("test reset done");
   strobes(60, 10, 10);
   chk("code external", 8'h01, {7'h00, cext});
   xd <= 1'b1;
   repeat (24) @(posedge clk);
   strobes(60, 5, 0);
   xd <= 1'b0;
   repeat (24) @(posedge clk);
   $display("test strobes done");
   wr_reg(8'h8E, 8'h01);
   rd_reg(8'h8E, v); chk("aux set", 8'h01, v);
   strobes(48, 0, 8);
   chk("latch pullup", 8'h01, {7'h00, ale_pu});
   wr_reg(8'h8E, 8'h00);
   repeat (12) @(posedge clk);
   strobes(24, 4, 4);
   $display("test emission done");
   wr_reg(8'h87, 8'h01);
   repeat (2) @(posedge clk);
   #1 chk("idle strobes", 8'h0F, {4'h0, pg_oe, pg_o, ale_oe, ale_o});
   chk("idle run pca", 8'h00, {6'h00, cpu, programmable_counter_array});
   chk("idle port2", 8'h03, {6'h00, p2a, p0f});
   rd_reg(8'h8F, v); chk("status idle", 8'h01, v);
   pend <= 1'b1;
   @(posedge clk);
   pend <= 1'b0;
   for (n = 0; n < 20 && cpu !== 1'b1; n++) @(posedge clk);
   chk("idle irq exit", 8'h01, {7'h00, cpu});
   wr_reg(8'h87, 8'h05);
   repeat (2) @(posedge clk);
   #1 chk("idle pca on", 8'h01, {7'h00, programmable_counter_array});
   rpin <= 1'b1;
   for (n = 0; n < 20 && rinh !== 1'b1; n++) @(posedge clk);
   #1 chk("idle rst ram", 8'h03, {6'h00, cpu, rinh});
   rpin <= 1'b0;
   pin_reset();
   $display("test idle done");
   wr_reg(8'h8E, 8'h01);
   wr_reg(8'h88, 8'h05);
   wr_reg(8'h87, 8'h02);
   repeat (2) @(posedge clk);
   #1 chk("down osc", 8'h00, {6'h00, osc, cpu});
   chk("down strobes", 8'h0A, {4'h0, pg_oe, pg_o, ale_oe, ale_o});
   chk("down port2", 8'h00, {7'h00, p2a});
   wreq <= 1'b1;
   for (n = 0; n < 20 && osc !== 1'b1; n++) @(posedge clk);
   #1 chk("osc restart", 8'h01, {7'h00, osc});
   wreq <= 1'b0;
   for (n = 0; n < 100 && wake !== 1'b1; n++) @(negedge clk);
   chk("wake run", 8'h03, {6'h00, wake, cpu});
   rd_reg(8'h8E, v); chk("aux kept", 8'h01, v);
   wr_reg(8'h87, 8'h02);
   pin_reset();
   rd_reg(8'h8E, v); chk("aux cleared", 8'h00, v);
   $display("test power down done");
   hold <= 1'b1;
   pin_reset();
   #1 chk("once", 8'h03, {6'h00, once, p0f});
   chk("once pins", 8'h07, {4'h0, pg_oe, pg_pu, ale_pu, osc});
   hold <= 1'b0;
   pin_reset();
   #1 chk("once left", 8'h00, {7'h00, once});
   lock <= 2'b01;
   pin_reset();
   sel <= 1'b1;
   repeat (8) @(posedge clk);
   #1 chk("select latched", 8'h01, {7'h00, cext});
   lock <= 2'b00;
   pin_reset();
   repeat (8) @(posedge clk);
   #1 chk("select internal", 8'h00, {7'h00, cext});
   $display("test once and lock done");
   end_of_test();
end
endmodule // test_power_mode_bus_strobe_ctrl
